// [core/interval_timer.sv]
// Interval counter stepped by the slow reference tick
`timescale 1ns/1ps
module interval_timer #(
    parameter int W = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic tick_i,
    input wire logic [W-1:0] count_i,
    output logic done_o
);
    logic [W-1:0] remain_r;
    logic busy_r;

    // Counts down one step per slow tick
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            remain_r <= '0;
            busy_r <= 1'b0;
            done_o <= 1'b0;
        end else if (start_i) begin
            remain_r <= count_i;
            busy_r <= 1'b1;
            done_o <= 1'b0;
        end else if (busy_r && remain_r == '0) begin
            busy_r <= 1'b0;
            done_o <= 1'b1;
        end else begin
            done_o <= 1'b0;
            if (busy_r && tick_i) begin
                remain_r <= remain_r - W'(1);
            end
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    a_zero_interval: assert property ( // R7
        (start_i && count_i == '0) |=> !done_o ##1 done_o)
        else $error("Zero interval did not finish at once");
    a_no_done_idle: assert property ( // R8
        done_o |=> !done_o)
        else $error("Interval end held longer than one cycle");
endmodule

// [core/touch_adc_status.sv]
// Status flags, interval timers and touch result FIFO of the touch ADC
`timescale 1ns/1ps
`include "touch_adc_consts.svh"
module touch_adc_status #(
    parameter int INTERVAL_W = 16,
    parameter int FIFO_DEPTH = 2
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rd_data_o,
    input wire logic pen_touched_evt_i,
    input wire logic pen_lifted_evt_i,
    input wire logic battery_done_i,
    input wire logic aux_done_i,
    input wire logic sample_valid_i,
    input wire logic [11:0] sample_i,
    output logic sample_accept_o,
    input wire logic same_start_i,
    input wire logic wait_start_i,
    output logic same_done_o,
    output logic wait_done_o,
    output logic [1:0] sequence_select_o,
    output logic differential_select_o,
    output logic pair_select_o,
    output logic irq_o
);
    localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam int ACC_W = $clog2(`TICK_MODULUS + `REF_CLK_MHZ);

    logic [`FLAGS_W-1:0] flags_r;
    logic [`FLAGS_W-1:0] mask_r;
    logic [3:0] config_r;
    logic [INTERVAL_W-1:0] same_point_interval_r;
    logic [INTERVAL_W-1:0] settle_wait_interval_r;
    logic [31:0] fifo_mem_r [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    touch_adc_pkg::point_phase_t phase_r;
    logic point_open_r;
    logic point_open_nxt;
    logic [1:0] mode_r;
    logic tag_r;
    logic [`SAMPLE_W-1:0] low_hold_r;
    logic [ACC_W-1:0] acc_r;
    logic tick_r;

    logic wr_flags, wr_mask, wr_clear, wr_same, wr_wait, wr_touch, wr_cfg;
    logic rd_touch;
    logic [`FLAGS_W-1:0] clear_bits;
    logic [`FLAGS_W-1:0] events;
    logic take;
    logic push;
    logic pop;
    logic point_done;
    logic [31:0] push_word;
    logic [1:0] first_mode;
    logic first_tag;

    assign wr_flags = wr_i && addr_i == `ADDR_FLAGS;
    assign wr_mask = wr_i && addr_i == `ADDR_MASK;
    assign wr_clear = wr_i && addr_i == `ADDR_CLEAR;
    assign wr_same = wr_i && addr_i == `ADDR_SAME;
    assign wr_wait = wr_i && addr_i == `ADDR_WAIT;
    assign wr_touch = wr_i && addr_i == `ADDR_TOUCH;
    assign wr_cfg = wr_i && addr_i == `ADDR_CONFIG;
    assign rd_touch = rd_i && addr_i == `ADDR_TOUCH;

    function automatic logic [31:0] pack_word(
        input logic [`SAMPLE_W-1:0] hi,
        input logic [`SAMPLE_W-1:0] lo,
        input logic tag
    );
        logic [31:0] w;
        w = '0;
        w[`HI_TAG_BIT] = tag;
        w[`HI_LSB +: `SAMPLE_W] = hi;
        w[`LO_TAG_BIT] = tag;
        w[`LO_LSB +: `SAMPLE_W] = lo;
        return w;
    endfunction

    // Slow tick at reference over prescale, fractional accumulator
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            acc_r <= '0;
            tick_r <= 1'b0;
        end else if (acc_r + ACC_W'(`REF_CLK_MHZ) >=
                     ACC_W'(`TICK_MODULUS)) begin
            acc_r <= acc_r + ACC_W'(`REF_CLK_MHZ) -
                     ACC_W'(`TICK_MODULUS);
            tick_r <= 1'b1;
        end else begin
            acc_r <= acc_r + ACC_W'(`REF_CLK_MHZ);
            tick_r <= 1'b0;
        end
    end

    interval_timer #(
        .W(INTERVAL_W)
    ) same_timer (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .start_i(same_start_i),
        .tick_i(tick_r), // R7
        .count_i(same_point_interval_r),
        .done_o(same_done_o)
    );

    interval_timer #(
        .W(INTERVAL_W)
    ) wait_timer (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .start_i(wait_start_i),
        .tick_i(tick_r), // R8
        .count_i(settle_wait_interval_r),
        .done_o(wait_done_o)
    );

    // Software settings
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mask_r <= `MASK_RST;
            config_r <= `CONFIG_RST;
            same_point_interval_r <= '0;
            settle_wait_interval_r <= '0;
        end else begin
            if (wr_mask) begin
                mask_r <= wr_data_i[`FLAGS_W-1:0]; // R17
            end
            if (wr_cfg) begin
                config_r <= wr_data_i[3:0];
            end
            if (wr_same) begin
                same_point_interval_r <= wr_data_i[INTERVAL_W-1:0]; // R7
            end
            if (wr_wait) begin
                settle_wait_interval_r <= wr_data_i[INTERVAL_W-1:0]; // R8
            end
        end
    end

    always_comb begin
        sequence_select_o = config_r[`CFG_SEQ_LSB +: 2];
        differential_select_o = config_r[`CFG_DIFF_BIT];
        pair_select_o = config_r[`CFG_PAIR_BIT];
    end

    // Event flags, set wins over clear
    always_comb begin
        events = '0;
        events[`FLAG_PEN_TOUCHED] = pen_touched_evt_i; // R1
        events[`FLAG_PEN_LIFTED] = pen_lifted_evt_i; // R2
        events[`FLAG_TOUCH_READY] = point_done; // R3
        events[`FLAG_BATTERY_READY] = battery_done_i; // R4
        events[`FLAG_AUX_READY] = aux_done_i; // R5
        clear_bits = '0;
        if (wr_flags || wr_clear) begin
            clear_bits = wr_data_i[`FLAGS_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            flags_r <= `FLAGS_RST;
        end else begin
            flags_r <= (flags_r & ~clear_bits) | events; // R1 R2 R3 R4 R5
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flags_r & ~mask_r); // R18
        end
    end

    // Sample packing per point
    assign take = sample_valid_i && sample_accept_o;
    assign first_mode = (phase_r == touch_adc_pkg::PH_FIRST) ?
                        config_r[`CFG_SEQ_LSB +: 2] : mode_r;
    assign first_tag = (first_mode == `SEQ_FOUR ||
                        first_mode == `SEQ_FOUR_ALT) &&
                       config_r[`CFG_PAIR_BIT]; // R12 R13

    always_comb begin
        push = 1'b0;
        point_done = 1'b0;
        push_word = '0;
        if (take) begin
            case (phase_r)
                touch_adc_pkg::PH_FIRST: begin
                    push = 1'b0;
                end
                touch_adc_pkg::PH_SECOND: begin
                    push = 1'b1;
                    push_word = pack_word(sample_i, low_hold_r, tag_r); // R10
                    point_done = (mode_r == `SEQ_POS_ONLY); // R13
                end
                touch_adc_pkg::PH_THIRD: begin
                    if (mode_r == `SEQ_POS_PRESS) begin
                        push = 1'b1;
                        push_word = pack_word('0, sample_i, 1'b0); // R14
                        point_done = 1'b1;
                    end
                end
                touch_adc_pkg::PH_FOURTH: begin
                    push = 1'b1;
                    push_word = pack_word(sample_i, low_hold_r, tag_r); // R15
                    point_done = 1'b1;
                end
                default: begin
                    push = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            phase_r <= touch_adc_pkg::PH_FIRST;
            mode_r <= `SEQ_POS_ONLY;
            tag_r <= 1'b0;
            low_hold_r <= '0;
        end else if (take) begin
            case (phase_r)
                touch_adc_pkg::PH_FIRST: begin
                    mode_r <= first_mode;
                    tag_r <= first_tag;
                    low_hold_r <= sample_i;
                    phase_r <= touch_adc_pkg::PH_SECOND;
                end
                touch_adc_pkg::PH_SECOND: begin
                    phase_r <= point_done ? touch_adc_pkg::PH_FIRST :
                               touch_adc_pkg::PH_THIRD;
                end
                touch_adc_pkg::PH_THIRD: begin
                    low_hold_r <= sample_i;
                    phase_r <= point_done ? touch_adc_pkg::PH_FIRST :
                               touch_adc_pkg::PH_FOURTH;
                end
                touch_adc_pkg::PH_FOURTH: begin
                    phase_r <= touch_adc_pkg::PH_FIRST;
                end
                default: begin
                    phase_r <= touch_adc_pkg::PH_FIRST;
                end
            endcase
        end
    end

    // Result FIFO
    assign pop = rd_touch && count_r != '0 && !wr_touch;

    always_comb begin
        count_nxt = count_r;
        if (wr_touch) begin
            count_nxt = push ? CNT_W'(1) : '0; // R11
        end else if (push && !pop) begin
            count_nxt = count_r + CNT_W'(1);
        end else if (pop && !push) begin
            count_nxt = count_r - CNT_W'(1);
        end
        point_open_nxt = point_open_r;
        if (point_done) begin
            point_open_nxt = 1'b0;
        end else if (take) begin
            point_open_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            point_open_r <= 1'b0;
            sample_accept_o <= 1'b1;
        end else begin
            count_r <= count_nxt; // R9
            point_open_r <= point_open_nxt;
            sample_accept_o <= point_open_nxt || count_nxt == '0; // R16
            if (wr_touch) begin
                rd_ptr_r <= '0;
                wr_ptr_r <= push ? PTR_W'(1) : '0; // R11
            end else begin
                if (push) begin
                    wr_ptr_r <= (wr_ptr_r == PTR_W'(FIFO_DEPTH - 1)) ?
                                '0 : wr_ptr_r + PTR_W'(1);
                end
                if (pop) begin
                    rd_ptr_r <= (rd_ptr_r == PTR_W'(FIFO_DEPTH - 1)) ?
                                '0 : rd_ptr_r + PTR_W'(1);
                end
            end
        end
    end

    generate
        for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_entry
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    fifo_mem_r[i] <= '0;
                end else if (push && wr_touch && i == 0) begin
                    fifo_mem_r[i] <= push_word;
                end else if (wr_touch) begin
                    fifo_mem_r[i] <= '0; // R11
                end else if (push && wr_ptr_r == PTR_W'(i)) begin
                    fifo_mem_r[i] <= push_word; // R9
                end
            end
        end
    endgenerate

    // Read port, data one cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                `ADDR_FLAGS: rd_data_o <= {27'h0, flags_r}; // R6
                `ADDR_MASK: rd_data_o <= {27'h0, mask_r};
                `ADDR_SAME: rd_data_o <= 32'(same_point_interval_r);
                `ADDR_WAIT: rd_data_o <= 32'(settle_wait_interval_r);
                `ADDR_TOUCH: begin
                    rd_data_o <= (count_r != '0) ?
                                 fifo_mem_r[rd_ptr_r] : '0; // R9
                end
                `ADDR_CONFIG: rd_data_o <= {28'h0, config_r};
                default: rd_data_o <= '0;
            endcase
        end else begin
            rd_data_o <= '0;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    sequence s_touch_evt;
        pen_touched_evt_i && wr_clear &&
            wr_data_i[`FLAG_PEN_TOUCHED];
    endsequence
    sequence s_flag_held;
        flags_r[`FLAG_PEN_TOUCHED] ##1 irq_o || mask_r[`FLAG_PEN_TOUCHED];
    endsequence

    a_set_beats_clear: assert property ( // R1
        s_touch_evt |=> flags_r[`FLAG_PEN_TOUCHED])
        else $error("Pen touched event lost under clear");
    a_lift_clear: assert property ( // R2
        (wr_flags && wr_data_i[`FLAG_PEN_LIFTED] && !pen_lifted_evt_i)
        |=> !flags_r[`FLAG_PEN_LIFTED])
        else $error("Pen lifted flag not cleared");
    a_touch_ready_set: assert property ( // R3
        point_done |=> flags_r[`FLAG_TOUCH_READY])
        else $error("Touch ready flag not set");
    a_battery_set: assert property ( // R4
        battery_done_i |=> flags_r[`FLAG_BATTERY_READY])
        else $error("Battery ready flag not set");
    a_aux_set: assert property ( // R5
        aux_done_i |=> flags_r[`FLAG_AUX_READY])
        else $error("Aux ready flag not set");
    a_flags_upper_zero: assert property ( // R6
        (rd_i && addr_i == `ADDR_FLAGS) |=> rd_data_o[31:5] == '0)
        else $error("Reserved flag bits read nonzero");
    a_word_reserved: assert property ( // R10
        (rd_i && addr_i == `ADDR_TOUCH) |=>
        rd_data_o[30:28] == '0 && rd_data_o[14:12] == '0)
        else $error("Reserved touch bits read nonzero");
    a_write_empties: assert property ( // R11
        (wr_touch && !push) |=>
        count_r == '0 ##1 (count_r == '0 || $past(push)))
        else $error("Write to touch port kept data");
    a_point_blocked: assert property ( // R16
        (count_r != '0 && !point_open_r) |-> !sample_accept_o)
        else $error("Next point accepted before read out");
    a_position_tags: assert property ( // R13
        (push && mode_r != `SEQ_FOUR && mode_r != `SEQ_FOUR_ALT) |->
        !push_word[`HI_TAG_BIT] && !push_word[`LO_TAG_BIT])
        else $error("Position mode tag not zero");
    a_irq_unmasked: assert property ( // R18
        (pen_touched_evt_i && !mask_r[`FLAG_PEN_TOUCHED] && !wr_mask)
        |=> s_flag_held)
        else $error("Interrupt not raised for unmasked flag");
    a_fifo_bound: assert property ( // R9
        count_r <= CNT_W'(FIFO_DEPTH))
        else $error("Result store overfilled");
endmodule

// [include/touch_adc_consts.svh]
// Offsets, field positions, reset values and timing of the touch ADC block
// How it works
// R1: Bit 4 pen touched, write one clears
// R2: Bit 3 pen lifted, write one clears
// R3: Bit 2 touch result ready, write one clears
// R4: Bit 1 battery or test result ready
// R5: Bit 0 auxiliary result ready, write one clears
// R6: Flag bits 7 to 5 read zero
// R7: Same point interval counts 12 MHz over 128
// R8: Settle wait interval counts 12 MHz over 128
// R9: Touch results sit in two word FIFO
// R10: Word packs two samples with tags
// R11: Writing result port clears its contents
// R12: Four measurement tag marks pressure pair used
// R13: Position modes give zero tags
// R14: Position plus pressure gives two words
// R15: Four measurement second word holds pressure pair
// R16: Next point waits until words read out
// R17: Mask bit per flag, one masks
// R18: Interrupt high while unmasked flag set
`ifndef TOUCH_ADC_CONSTS_SVH
`define TOUCH_ADC_CONSTS_SVH

`define ADDR_FLAGS 8'h00
`define ADDR_MASK 8'h04
`define ADDR_CLEAR 8'h08
`define ADDR_SAME 8'h0C
`define ADDR_WAIT 8'h10
`define ADDR_TOUCH 8'h14
`define ADDR_CONFIG 8'h18

`define FLAGS_W 5
`define FLAG_PEN_TOUCHED 4
`define FLAG_PEN_LIFTED 3
`define FLAG_TOUCH_READY 2
`define FLAG_BATTERY_READY 1
`define FLAG_AUX_READY 0

`define FLAGS_RST 5'h00
`define MASK_RST 5'h1F
`define CONFIG_RST 4'h0

`define CFG_SEQ_LSB 0
`define CFG_DIFF_BIT 2
`define CFG_PAIR_BIT 3

`define SEQ_POS_ONLY 2'h0
`define SEQ_POS_PRESS 2'h1
`define SEQ_FOUR 2'h2
`define SEQ_FOUR_ALT 2'h3

`define SAMPLE_W 12
`define HI_TAG_BIT 31
`define HI_LSB 16
`define LO_TAG_BIT 15
`define LO_LSB 0

`define REF_CLK_MHZ 12
`define CLK_SYS_MHZ 200
`define INTERVAL_PRESCALE 128
`define TICK_MODULUS (`CLK_SYS_MHZ * `INTERVAL_PRESCALE)

`endif

// [include/touch_adc_pkg.sv]
// Types of the touch ADC block
package touch_adc_pkg;

    typedef enum logic [3:0] {
        PH_FIRST = 4'b0001,
        PH_SECOND = 4'b0010,
        PH_THIRD = 4'b0100,
        PH_FOURTH = 4'b1000
    } point_phase_t;

endpackage

// [testbench/converter_model.sv]
// Converter model presenting touch samples one at a time
`timescale 1ns/1ps
module converter_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic send_i,
    input wire logic [2:0] count_i,
    input wire logic [47:0] samples_i,
    input wire logic sample_accept_i,
    output logic sample_valid_o,
    output logic [11:0] sample_o,
    output logic busy_o
);
    logic [2:0] idx_r;
    logic [2:0] cnt_r;
    logic [47:0] vals_r;
    // Samples held until taken, order X, Y, then pressure
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            idx_r <= 3'h0;
            cnt_r <= 3'h0;
            vals_r <= 48'h0;
            busy_o <= 1'b0;
            sample_valid_o <= 1'b0;
            sample_o <= 12'hA5A;
        end else if (send_i && !busy_o) begin
            vals_r <= samples_i;
            cnt_r <= count_i;
            idx_r <= 3'h0;
            busy_o <= 1'b1;
            sample_valid_o <= 1'b1;
            sample_o <= samples_i[11:0];
        end else if (sample_valid_o && sample_accept_i) begin
            if (idx_r + 3'h1 == cnt_r) begin
                sample_valid_o <= 1'b0;
                busy_o <= 1'b0;
                sample_o <= ~sample_o;
            end else begin
                idx_r <= idx_r + 3'h1;
                sample_o <= vals_r[12 * (idx_r + 3'h1) +: 12];
            end
        end
    end
endmodule

// [testbench/test_touch_adc_status.sv]
// Self-checking bench of the touch ADC status block
`timescale 1ns/1ps
module test_touch_adc_status;
    typedef struct {
        logic [3:0] cfg;
        logic [2:0] n;
        logic [47:0] s;
        logic [31:0] w0;
        logic [31:0] w1;
    } row_t;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wr_data_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rd_data_o;
    logic [3:0] ev = 4'h0;
    logic sample_valid_i;
    logic [11:0] sample_i;
    logic sample_accept_o;
    logic same_start_i = 1'b0;
    logic wait_start_i = 1'b0;
    logic same_done_o;
    logic wait_done_o;
    logic [1:0] sequence_select_o;
    logic differential_select_o;
    logic pair_select_o;
    logic irq_o;
    logic send = 1'b0;
    logic [2:0] cnt = 3'h0;
    logic [47:0] smp = 48'h0;
    logic busy;
    row_t rows [4];
    logic [31:0] d;
    int error_cnt = 0;
    int checks = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    touch_adc_status i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
        .rd_data_o(rd_data_o), .pen_touched_evt_i(ev[3]),
        .pen_lifted_evt_i(ev[2]), .battery_done_i(ev[1]),
        .aux_done_i(ev[0]), .sample_valid_i(sample_valid_i),
        .sample_i(sample_i), .sample_accept_o(sample_accept_o),
        .same_start_i(same_start_i), .wait_start_i(wait_start_i),
        .same_done_o(same_done_o), .wait_done_o(wait_done_o),
        .sequence_select_o(sequence_select_o),
        .differential_select_o(differential_select_o),
        .pair_select_o(pair_select_o), .irq_o(irq_o));

    converter_model i_conv (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .send_i(send), .count_i(cnt), .samples_i(smp),
        .sample_accept_i(sample_accept_o), .sample_valid_o(sample_valid_i),
        .sample_o(sample_i), .busy_o(busy));

    task automatic step();
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        addr_i <= a;
        wr_data_i <= v;
        wr_i <= 1'b1;
        step();
        wr_i <= 1'b0;
        step();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        addr_i <= a;
        rd_i <= 1'b1;
        step();
        rd_i <= 1'b0;
        v = rd_data_o;
        step();
    endtask

    task automatic pulse(input logic [3:0] e);
        ev <= e;
        step();
        ev <= 4'h0;
        step();
    endtask

    task automatic point(input logic [2:0] n, input logic [47:0] s);
        int c;
        cnt <= n;
        smp <= s;
        send <= 1'b1;
        step();
        send <= 1'b0;
        c = 0;
        while (busy !== 1'b0 && c < 50) begin
            step();
            c++;
        end
        repeat (3) step();
    endtask

    task automatic timer(input logic sel, input logic [31:0] n,
                         input int lo, input int hi);
        int c;
        wr(sel ? 8'h0C : 8'h10, n);
        if (sel) same_start_i <= 1'b1;
        else wait_start_i <= 1'b1;
        step();
        same_start_i <= 1'b0;
        wait_start_i <= 1'b0;
        c = 0;
        while ((sel ? same_done_o : wait_done_o) !== 1'b1 && c < 5000) begin
            step();
            c++;
        end
        chk("timer in range", 32'h1, {31'h0, c >= lo && c <= hi});
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end

    initial begin
        rows[0] = '{4'h0, 3'h2, 48'h0000_0022_2111, 32'h0222_0111, 32'h0};
        rows[1] = '{4'h5, 3'h3, 48'h0007_8945_6123, 32'h0456_0123,
                    32'h0000_0789};
        rows[2] = '{4'hA, 3'h4, 48'h2461_35DE_FABC, 32'h8DEF_8ABC,
                    32'h8246_8135};
        rows[3] = '{4'h3, 3'h4, 48'h8000_0100_0FFF, 32'h0000_0FFF,
                    32'h0800_0001};
        repeat (5) step();
        rst_i <= 1'b0;
        step();
        chk("irq after reset", 32'h0, {31'h0, irq_o});
        chk("accept after reset", 32'h1, {31'h0, sample_accept_o});
        rd(8'h04, d);
        chk("mask reset", 32'h1F, d);
        for (int i = 0; i < 4; i++) begin
            wr(8'h18, {28'h0, rows[i].cfg});
            chk("config", {28'h0, rows[i].cfg}, {28'h0, pair_select_o,
                differential_select_o, sequence_select_o});
            rd(8'h18, d);
            chk("config read", {28'h0, rows[i].cfg}, d);
            point(rows[i].n, rows[i].s);
            rd(8'h00, d);
            chk("touch ready", 32'h04, d);
            chk("accept held low", 32'h0, {31'h0, sample_accept_o});
            rd(8'h14, d);
            chk("first word", rows[i].w0, d);
            if (rows[i].n > 3'h2) begin
                rd(8'h14, d);
                chk("second word", rows[i].w1, d);
            end
            chk("accept back", 32'h1, {31'h0, sample_accept_o});
            rd(8'h14, d);
            chk("empty fifo", 32'h0, d);
            wr(8'h00, 32'h04);
            rd(8'h00, d);
            chk("touch ready cleared", 32'h0, d);
        end
        $display("test sample rows done");
        wr(8'h18, 32'h0);
        point(3'h2, 48'h0000_0033_3444);
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14, d);
        chk("port write clears", 32'h0, d);
        chk("accept after clear", 32'h1, {31'h0, sample_accept_o});
        wr(8'h00, 32'h04);
        $display("test port clear done");
        point(3'h2, 48'h0000_0055_5666);
        rst_i <= 1'b1;
        repeat (2) step();
        rst_i <= 1'b0;
        step();
        chk("accept mid reset", 32'h1, {31'h0, sample_accept_o});
        chk("irq mid reset", 32'h0, {31'h0, irq_o});
        rd(8'h14, d);
        chk("fifo mid reset", 32'h0, d);
        rd(8'h00, d);
        chk("flags mid reset", 32'h0, d);
        rd(8'h04, d);
        chk("mask mid reset", 32'h1F, d);
        $display("test mid reset done");
        pulse(4'h8);
        pulse(4'h4);
        pulse(4'h2);
        pulse(4'h1);
        rd(8'h00, d);
        chk("event flags", 32'h1B, d);
        wr(8'h00, 32'hFFFF_FFE8);
        rd(8'h00, d);
        chk("pen lifted cleared", 32'h13, d);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        wr(8'h04, 32'h0F);
        pulse(4'h8);
        step();
        chk("irq pen touched", 32'h1, {31'h0, irq_o});
        wr(8'h00, 32'h10);
        step();
        chk("irq after clear", 32'h0, {31'h0, irq_o});
        wr(8'h04, 32'h1C);
        step();
        chk("irq low flags", 32'h1, {31'h0, irq_o});
        wr(8'h00, 32'h03);
        step();
        chk("irq all clear", 32'h0, {31'h0, irq_o});
        rd(8'h00, d);
        chk("flags clear", 32'h0, d);
        addr_i <= 8'h08;
        wr_data_i <= 32'h10;
        wr_i <= 1'b1;
        ev <= 4'h8;
        step();
        wr_i <= 1'b0;
        ev <= 4'h0;
        step();
        rd(8'h00, d);
        chk("set beats clear", 32'h10, d);
        wr(8'h08, 32'h10);
        rd(8'h00, d);
        chk("clear register", 32'h0, d);
        wr(8'h04, 32'h1F);
        $display("test flags done");
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, d);
        chk("unmapped", 32'h0, d);
        timer(1'b1, 32'h0, 1, 2);
        timer(1'b1, 32'h2, 2130, 4300);
        timer(1'b0, 32'h2, 2130, 4300);
        rd(8'h0C, d);
        chk("same interval", 32'h2, d);
        rd(8'h10, d);
        chk("settle interval", 32'h2, d);
        $display("test timers done");
        end_sim();
    end
endmodule
